// ---- rtl/ecm_pkg.sv ----
// Shared constants and carrier types for the 8b/10b character codec.
package ecm_pkg;

  // ************************************************************
  // Character framing.
  // ************************************************************
  localparam logic [3:0] ECM_LAST_BIT = 4'h9;
  localparam logic [3:0] ECM_CNT_RESET = 4'h9;
  localparam logic [9:0] ECM_SHIFT_RESET = 10'h000;
  localparam logic [6:0] ECM_COMMA_POS = 7'h1f;
  localparam logic [6:0] ECM_COMMA_NEG = 7'h60;
  localparam logic [7:0] ECM_IDLE_BYTE = 8'hbc;

  // ************************************************************
  // Running disparity and special sub-block patterns.
  // ************************************************************
  localparam logic ECM_RD_NEG = 1'b0;
  localparam logic [5:0] ECM_SIX_FORCE_POS = 6'h07;
  localparam logic [5:0] ECM_SIX_FORCE_NEG = 6'h38;
  localparam logic [3:0] ECM_FOUR_FORCE_POS = 4'h3;
  localparam logic [3:0] ECM_FOUR_FORCE_NEG = 4'hc;
  localparam logic [5:0] ECM_SIX_K28 = 6'h0f;
  localparam logic [3:0] ECM_FOUR_ALT = 4'h7;
  localparam logic [4:0] ECM_X_K28 = 5'h1c;
  localparam logic [2:0] ECM_Y_ALT = 3'h7;

  // ************************************************************
  // Carrier types.
  // ************************************************************
  typedef struct packed {
    logic special;
    logic [7:0] data;
  } ecm_char_s;

  typedef struct packed {
    ecm_char_s rxChar;
    logic rxValid;
    logic rxViolation;
    logic rxAligned;
    logic rxRd;
    logic [9:0] rxWindow;
    logic [3:0] rxCnt;
    logic rxSync1;
    logic rxSync2;
    logic txRd;
    logic [9:0] txShift;
    logic [3:0] txCnt;
    logic txReady;
  } ecm_state_s;

endpackage : ecm_pkg

// ---- rtl/ecm_codec.sv ----
// 8b/10b character encoder with serializer and deserializer with aligner and decoder.
//
// Contract
// - Each accepted byte becomes one 10-bit character, shifted out one bit per cycle.
// - Received bits are grouped by ten and decoded back into bytes.
// - All 256 byte values encode; extra characters serve as special codes.
// - Byte bit 0 is letter A through bit 7 as H; a..h match.
// - Bit i derives from A..E, bit j from F..H.
// - Special select low sends data, high sends a special character.
// - Dxx.y has EDCBA equal to xx and HGF equal to y.
// - Line carries enough transitions; idle sends comma characters between bytes.
// - Comma patterns in the received stream set character boundaries.
// - Serial order is a, b, c, d, e, i, f, g, h, j.
// - Disparity updates per sub-block by ones count and forcing patterns.
// - Characters outside the disparity column flag a violation yet update disparity.
`timescale 1ns/1ps
module ecm_codec (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire ecm_pkg::ecm_char_s txChar,
  input wire logic txValid,
  output logic txReady,
  output logic serialOut,
  input wire logic serialIn,
  output ecm_pkg::ecm_char_s rxChar,
  output logic rxValid,
  output logic rxViolation,
  output logic rxAligned
);
  import ecm_pkg::*;

  // ************************************************************
  // Code tables and helpers.
  // ************************************************************
  function automatic logic [5:0] tab6(input logic [4:0] x);
    case (x)
      5'h00: tab6 = 6'h27;
      5'h01: tab6 = 6'h1d;
      5'h02: tab6 = 6'h2d;
      5'h03: tab6 = 6'h31;
      5'h04: tab6 = 6'h35;
      5'h05: tab6 = 6'h29;
      5'h06: tab6 = 6'h19;
      5'h07: tab6 = 6'h38;
      5'h08: tab6 = 6'h39;
      5'h09: tab6 = 6'h25;
      5'h0a: tab6 = 6'h15;
      5'h0b: tab6 = 6'h34;
      5'h0c: tab6 = 6'h0d;
      5'h0d: tab6 = 6'h2c;
      5'h0e: tab6 = 6'h1c;
      5'h0f: tab6 = 6'h17;
      5'h10: tab6 = 6'h1b;
      5'h11: tab6 = 6'h23;
      5'h12: tab6 = 6'h13;
      5'h13: tab6 = 6'h32;
      5'h14: tab6 = 6'h0b;
      5'h15: tab6 = 6'h2a;
      5'h16: tab6 = 6'h1a;
      5'h17: tab6 = 6'h3a;
      5'h18: tab6 = 6'h33;
      5'h19: tab6 = 6'h26;
      5'h1a: tab6 = 6'h16;
      5'h1b: tab6 = 6'h36;
      5'h1c: tab6 = 6'h0e;
      5'h1d: tab6 = 6'h2e;
      5'h1e: tab6 = 6'h1e;
      default: tab6 = 6'h2b;
    endcase
  endfunction : tab6

  function automatic logic [3:0] tab4(input logic [2:0] y);
    case (y)
      3'h0: tab4 = 4'hb;
      3'h1: tab4 = 4'h9;
      3'h2: tab4 = 4'h5;
      3'h3: tab4 = 4'hc;
      3'h4: tab4 = 4'hd;
      3'h5: tab4 = 4'ha;
      3'h6: tab4 = 4'h6;
      default: tab4 = 4'he;
    endcase
  endfunction : tab4

  function automatic logic [2:0] ones(input logic [5:0] v);
    ones = 3'h0;
    for (int n = 0; n < 6; n++) begin
      ones = ones + {2'h0, v[n]};
    end
  endfunction : ones

  // Sub-block disparity step; six-bit blocks balance at three ones, four-bit at two.
  function automatic logic rdStep(input logic rd, input logic [5:0] v, input logic six);
    logic [2:0] half;
    logic [2:0] cnt;
    half = six ? 3'h3 : 3'h2;
    cnt = ones(v);
    if (cnt > half) begin
      rdStep = 1'b1;
    end else if (cnt < half) begin
      rdStep = 1'b0;
    end else if (six) begin
      rdStep = (v == ECM_SIX_FORCE_POS) ? 1'b1 : ((v == ECM_SIX_FORCE_NEG) ? 1'b0 : rd);
    end else begin
      rdStep = (v[3:0] == ECM_FOUR_FORCE_POS) ? 1'b1 : ((v[3:0] == ECM_FOUR_FORCE_NEG) ? 1'b0 : rd);
    end
  endfunction : rdStep

  function automatic logic rdAfter(input logic rd, input logic [9:0] c);
    rdAfter = rdStep(rdStep(rd, c[9:4], 1'b1), {2'h0, c[3:0]}, 1'b0);
  endfunction : rdAfter

  // Codes that differ between the two disparity columns.
  function automatic logic flip6(input logic [5:0] v);
    flip6 = (ones(v) != 3'h3) || (v == ECM_SIX_FORCE_NEG);
  endfunction : flip6

  function automatic logic flip4(input logic [3:0] v);
    flip4 = (ones({2'h0, v}) != 3'h2) || (v == ECM_FOUR_FORCE_NEG);
  endfunction : flip4

  // Encodes one byte into abcdei fghj, a in bit 9.
  function automatic logic [9:0] enc(input ecm_char_s ch, input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic rdEff;
    logic rdMid;
    logic alt;
    logic [5:0] s6;
    logic [3:0] f4;
    x = ch.data[4:0];
    y = ch.data[7:5];
    rdEff = ch.special ? ECM_RD_NEG : rd;
    s6 = (ch.special && x == ECM_X_K28) ? ECM_SIX_K28 : tab6(x);
    if (rdEff && flip6(s6)) begin
      s6 = ~s6;
    end
    rdMid = rdStep(rdEff, s6, 1'b1);
    alt = (y == ECM_Y_ALT) && (ch.special || (!rdMid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (rdMid && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
    f4 = alt ? ECM_FOUR_ALT : tab4(y);
    if (rdMid && flip4(f4)) begin
      f4 = ~f4;
    end
    enc = (ch.special && rd) ? ~{s6, f4} : {s6, f4};
  endfunction : enc

  // Decodes a character from either column; validity is judged separately.
  function automatic ecm_char_s dec(input logic [9:0] c);
    logic [5:0] s6;
    logic [3:0] f4;
    logic [4:0] x;
    logic [2:0] y;
    logic k28;
    logic alt;
    s6 = c[9:4];
    f4 = c[3:0];
    x = 5'h00;
    y = 3'h0;
    for (int n = 0; n < 32; n++) begin
      if (tab6(n[4:0]) == s6 || (flip6(tab6(n[4:0])) && ~tab6(n[4:0]) == s6)) begin
        x = n[4:0];
      end
    end
    k28 = (s6 == ECM_SIX_K28) || (s6 == ~ECM_SIX_K28);
    if (k28) begin
      x = ECM_X_K28;
    end
    if (s6 == ~ECM_SIX_K28) begin
      f4 = ~f4;
    end
    for (int n = 0; n < 8; n++) begin
      if (tab4(n[2:0]) == f4 || (flip4(tab4(n[2:0])) && ~tab4(n[2:0]) == f4)) begin
        y = n[2:0];
      end
    end
    alt = (f4 == ECM_FOUR_ALT) || (f4 == ~ECM_FOUR_ALT);
    if (alt) begin
      y = ECM_Y_ALT;
    end
    dec.special = k28 || (alt && (x == 5'h17 || x == 5'h1b || x == 5'h1d || x == 5'h1e));
    dec.data = {y, x};
  endfunction : dec

  // ************************************************************
  // State update.
  // ************************************************************
  ecm_state_s state;
  ecm_state_s next_state;

  always_comb begin
    ecm_char_s txSel;
    logic [9:0] txCode;
    logic [9:0] win;
    logic [9:0] rxCode;
    logic emit;
    logic comma;
    ecm_char_s got;
    txSel = txValid ? txChar : ecm_char_s'{special: 1'b1, data: ECM_IDLE_BYTE};
    txCode = enc(txSel, state.txRd);
    win = {state.rxWindow[8:0], state.rxSync2};
    comma = (win[9:3] == ECM_COMMA_POS) || (win[9:3] == ECM_COMMA_NEG);
    emit = comma || (state.rxCnt == ECM_LAST_BIT);
    rxCode = win;
    got = dec(rxCode);
    next_state = state;
    next_state.rxSync1 = serialIn;
    next_state.rxSync2 = state.rxSync1;
    next_state.rxWindow = win;
    next_state.rxValid = emit;
    next_state.rxViolation = 1'b0;
    next_state.rxCnt = emit ? 4'h0 : state.rxCnt + 4'h1;
    if (comma) begin
      next_state.rxAligned = 1'b1;
    end
    if (emit) begin
      next_state.rxChar = got;
      next_state.rxViolation = (enc(got, state.rxRd) != rxCode);
      next_state.rxRd = rdAfter(state.rxRd, rxCode);
    end
    if (state.txCnt == ECM_LAST_BIT) begin
      next_state.txShift = txCode;
      next_state.txRd = rdAfter(state.txRd, txCode);
      next_state.txCnt = 4'h0;
    end else begin
      next_state.txShift = {state.txShift[8:0], 1'b0};
      next_state.txCnt = state.txCnt + 4'h1;
    end
    next_state.txReady = (next_state.txCnt == ECM_LAST_BIT);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= '0;
      state.rxRd <= ECM_RD_NEG;
      state.txRd <= ECM_RD_NEG;
      state.txShift <= ECM_SHIFT_RESET;
      state.txCnt <= ECM_CNT_RESET;
      state.txReady <= 1'b1;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************
  assign txReady = state.txReady;
  assign serialOut = state.txShift[9];
  assign rxChar = state.rxChar;
  assign rxValid = state.rxValid;
  assign rxViolation = state.rxViolation;
  assign rxAligned = state.rxAligned;

endmodule : ecm_codec

// ---- dv/ecm_codec_monitor.sv ----
// Port checker for the character codec.
`timescale 1ns/1ps
module ecm_codec_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic serialOut,
  input wire ecm_pkg::ecm_char_s rxChar,
  input wire logic rxValid,
  input wire logic rxViolation,
  input wire logic rxAligned
);
  import ecm_pkg::*;
  // ***
  // Load spacing and line checks.
  // ***
  logic [3:0] loadGap;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      loadGap <= 4'h0;
    end else if (clkEn) begin
      loadGap <= txReady ? 4'h1 : loadGap + 4'h1;
    end
  end
  sequence s_comma_neg;
    !serialOut [*2] ##1 serialOut [*4];
  endsequence
  sequence s_comma_pos;
    serialOut [*2] ##1 !serialOut [*4];
  endsequence
  a_ready_gap: assert property (txReady |-> loadGap == 4'h0 || loadGap == 4'ha)
    else $error("early load");
  a_ready_due: assert property (loadGap == 4'ha |-> txReady)
    else $error("missed load");
  a_ready_drop: assert property (txReady && clkEn |=> !txReady)
    else $error("ready held");
  a_freeze_line: assert property (!clkEn |=> $stable(serialOut) && $stable(txReady))
    else $error("moved while frozen");
  a_idle_comma: assert property (txReady && clkEn && !txValid |=> s_comma_neg or s_comma_pos)
    else $error("idle not comma");
  a_viol_valid: assert property (rxViolation |-> rxValid)
    else $error("stray violation");
  a_align_kept: assert property (rxAligned |=> rxAligned)
    else $error("align lost");
  a_align_comma: assert property ($rose(rxAligned) |-> rxValid && rxChar.special)
    else $error("align without comma");
  a_char_hold: assert property ($changed(rxChar) |-> rxValid)
    else $error("char moved");
  a_reset_state: assert property (disable iff (1'b0) !resetn |=> txReady && !serialOut && !rxAligned)
    else $error("bad reset state");
endmodule : ecm_codec_monitor
bind ecm_codec ecm_codec_monitor MON (.clk(clk), .resetn(resetn), .clkEn(clkEn), .txValid(txValid),
  .txReady(txReady), .serialOut(serialOut), .rxChar(rxChar), .rxValid(rxValid), .rxViolation(rxViolation),
  .rxAligned(rxAligned));

// ---- dv/ecm_far_end.sv ----
// Far end model: echoes the line or sends given characters.
`timescale 1ns/1ps
module ecm_far_end (
  input wire logic clk,
  input wire logic resetn,
  input wire logic lineIn,
  output logic lineOut
);
  // ***
  // Line source.
  // ***
  logic echo;
  logic usePat = 1'b0;
  logic patBit = 1'b0;
  always_ff @(posedge clk) begin
    echo <= resetn ? lineIn : 1'b0;
  end
  assign lineOut = usePat ? patBit : echo;
  task automatic send_pat(input logic [9:0] pat, input int reps);
    usePat = 1'b1;
    for (int n = 0; n < reps; n++) begin
      for (int k = 9; k >= 0; k--) begin
        patBit = pat[k];
        @(negedge clk);
      end
    end
    usePat = 1'b0;
  endtask : send_pat
endmodule : ecm_far_end

// ---- dv/tb_top.sv ----
// Self-checking testbench for the character codec.
`timescale 1ns/1ps
module tb_top;
  import ecm_pkg::*;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
  // ***
  // Design and far end.
  // ***
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic txValid = 1'b0;
  ecm_char_s txChar = '0;
  ecm_char_s rxChar;
  logic txReady, serialOut, serialIn, rxValid, rxViolation, rxAligned;
  int mismatches = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  ecm_codec DUT (.clk(clk), .resetn(resetn), .clkEn(clkEn), .txChar(txChar), .txValid(txValid), .txReady(txReady),
    .serialOut(serialOut), .serialIn(serialIn), .rxChar(rxChar), .rxValid(rxValid), .rxViolation(rxViolation),
    .rxAligned(rxAligned));
  ecm_far_end FAR (.clk(clk), .resetn(resetn), .lineIn(serialOut), .lineOut(serialIn));
  // ***
  // Scenarios.
  // ***
  task automatic wait_ready();
    for (int k = 0; k < 20 && txReady !== 1'b1; k++) begin
      @(negedge clk);
    end
  endtask : wait_ready
  task automatic tx_char(input ecm_char_s c, input logic [9:0] exp);
    logic [9:0] got;
    wait_ready();
    txChar = c;
    txValid = 1'b1;
    for (int k = 0; k < 10; k++) begin
      @(negedge clk);
      got = {got[8:0], serialOut};
    end
    `CHK(got, exp)
    `CHK(txReady, 1'b1)
  endtask : tx_char
  task automatic test_tx();
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    `CHK({txReady, serialOut, rxAligned}, 3'b100)
    tx_char({1'b0, 8'h45}, 10'h295);
    tx_char({1'b1, ECM_IDLE_BYTE}, 10'h0fa);
    tx_char({1'b1, ECM_IDLE_BYTE}, 10'h305);
    tx_char({1'b0, 8'h00}, 10'h274);
    tx_char({1'b0, 8'hff}, 10'h2b1);
  endtask : test_tx
  task automatic test_rx();
    for (int k = 0; k < 60 && rxAligned !== 1'b1; k++) begin
      @(negedge clk);
    end
    `CHK(rxAligned, 1'b1)
    tx_char({1'b0, 8'h45}, 10'h295);
    txValid = 1'b0;
    for (int k = 0; k < 30 && !(rxValid === 1'b1 && rxChar.data === 8'h45); k++) begin
      @(negedge clk);
    end
    `CHK({rxValid, rxViolation, rxChar}, {1'b1, 1'b0, 1'b0, 8'h45})
  endtask : test_rx
  task automatic test_viol();
    FAR.send_pat(10'h0fa, 2);
    for (int k = 0; k < 8 && rxValid !== 1'b1; k++) begin
      @(negedge clk);
    end
    `CHK({rxValid, rxViolation, rxChar.special}, 3'b111)
  endtask : test_viol
  task automatic test_freeze();
    logic s;
    wait_ready();
    txChar = {1'b0, 8'h45};
    txValid = 1'b1;
    @(negedge clk);
    clkEn = 1'b0;
    s = serialOut;
    repeat (3) begin
      @(negedge clk);
      `CHK({txReady, serialOut}, {1'b0, s})
    end
    clkEn = 1'b1;
  endtask : test_freeze
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    test_tx();
    test_rx();
    test_viol();
    test_freeze();
    wrap_up();
  end
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_top
